/* verilog/sev_pkg.sv */
// sev_pkg: constants and carrier types for the status event register bank
// assumes one 50 MHz system clock and a synchronous active-high reset
package sev_pkg;

    localparam int REG_WIDTH = 16;
    localparam logic [REG_WIDTH-1:0] LATCH_RESET = 16'h0000;

    // register selectors used on the query port
    localparam logic [1:0] SEL_MEASUREMENT = 2'h0;
    localparam logic [1:0] SEL_QUESTIONABLE = 2'h1;
    localparam logic [1:0] SEL_OPERATION = 2'h2;

    // measurement event bit positions
    localparam int BIT_READING_OVERFLOW = 0;
    localparam int BIT_LOWER_LIMIT_ONE = 1;
    localparam int BIT_UPPER_LIMIT_ONE = 2;
    localparam int BIT_LOWER_LIMIT_TWO = 3;
    localparam int BIT_UPPER_LIMIT_TWO = 4;
    localparam int BIT_READING_READY = 5;
    localparam int BIT_BUFFER_HAS_DATA = 7;
    localparam int BIT_BUFFER_HALF = 8;
    localparam int BIT_BUFFER_COMPLETE = 9;

    // questionable event bit positions
    localparam int BIT_TEMP_SUMMARY = 4;
    localparam int BIT_CAL_SUMMARY = 8;
    localparam int BIT_CMD_WARNING = 14;

    // operation event bit positions
    localparam int BIT_MEASURING = 4;
    localparam int BIT_TRIGGERING = 5;
    localparam int BIT_IDLE = 10;

    // implemented-bit masks, unused bits always read zero
    localparam logic [REG_WIDTH-1:0] MEAS_USED_MASK = 16'h03bf;
    localparam logic [REG_WIDTH-1:0] QUES_USED_MASK = 16'h4110;
    localparam logic [REG_WIDTH-1:0] OPER_USED_MASK = 16'h0430;

    // trace buffer fill thresholds
    localparam int BUF_COUNT_WIDTH = 11;
    localparam logic [BUF_COUNT_WIDTH-1:0] BUF_HAS_DATA_MIN = 11'h002;

    // event inputs from the measurement engine
    typedef struct packed {
        logic reading_done;
        logic reading_overflow;
        logic lower_limit_one_crossed;
        logic upper_limit_one_crossed;
        logic lower_limit_two_crossed;
        logic upper_limit_two_crossed;
    } sev_reading_type;

    // instrument state levels
    typedef struct packed {
        logic temp_ref_invalid;
        logic cal_constant_invalid;
        logic cal_done_ok;
        logic cmd_param_ignored;
        logic measuring;
        logic device_action;
        logic idle;
    } sev_state_type;

    // query port
    typedef struct packed {
        logic valid;
        logic [1:0] sel;
    } sev_query_type;

endpackage

/* verilog/sev_latch16.sv */
// sev_latch16: one 16-bit sticky event register cleared by a read
// assumes set inputs and read strobe on the same clock
`timescale 1ns/10ps
module sev_latch16
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [15:0] set_in,
    input wire logic [15:0] used_mask_in,
    input wire logic read_in,
    output logic [15:0] value_out
);
    import sev_pkg::*;

    logic [REG_WIDTH-1:0] latch_r;

    // sticky bits, an event arriving during the read clear is kept
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            latch_r <= LATCH_RESET;
        end
        else if (read_in)
        begin
            latch_r <= set_in & used_mask_in;
        end
        else
        begin
            latch_r <= (latch_r | set_in) & used_mask_in;
        end
    end

    assign value_out = latch_r;

endmodule // sev_latch16

/* verilog/sev_status_bank.sv */
// sev_status_bank: measurement, questionable and operation event latches
// assumes events come from logic on mclk_in; host queries via a strobe
//
// How it works
// [RL1] read of a register clears it afterwards
// [RL2] reply is the binary weighted register value
// [RL3] overflow reading sets measurement bit 0
// [RL4] below lower limit one sets bit 1
// [RL5] above upper limit one sets bit 2
// [RL6] below lower limit two sets bit 3
// [RL7] above upper limit two sets bit 4
// [RL8] processed reading sets bit 5
// [RL9] two or more buffered readings set bit 7
// [RL10] buffer half full sets bit 8
// [RL11] buffer full sets bit 9
// [RL12] invalid reference junction sets questionable bit 4
// [RL13] bad cal constant sets bit 8, default used
// [RL14] cal invalid holds until successful calibration
// [RL15] ignored command parameter sets bit 14
// [RL16] fault light follows questionable events
// [RL17] measuring sets operation bit 4
// [RL18] device action stage sets bit 5
// [RL19] idle state sets operation bit 10
// [RL20] enabled set bits drive summary outputs
// [RL21] bits sticky until read, unused read zero
`timescale 1ns/10ps
module sev_status_bank
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire sev_pkg::sev_reading_type reading_in,
    input wire sev_pkg::sev_state_type state_in,
    input wire logic [10:0] buf_count_in,
    input wire logic [10:0] buf_capacity_in,
    input wire sev_pkg::sev_query_type query_in,
    input wire logic [15:0] meas_enable_in,
    input wire logic [15:0] ques_enable_in,
    input wire logic [15:0] oper_enable_in,
    output logic reply_valid_out,
    output logic [15:0] reply_value_out,
    output logic use_default_cal_out,
    output logic fault_light_out,
    output logic meas_summary_out,
    output logic ques_summary_out,
    output logic oper_summary_out
);
    import sev_pkg::*;

    logic [REG_WIDTH-1:0] meas_set;
    logic [REG_WIDTH-1:0] ques_set;
    logic [REG_WIDTH-1:0] oper_set;
    logic [REG_WIDTH-1:0] meas_val;
    logic [REG_WIDTH-1:0] ques_val;
    logic [REG_WIDTH-1:0] oper_val;
    logic rd_meas;
    logic rd_ques;
    logic rd_oper;
    logic cal_invalid_r;
    logic cal_invalid_nxt;
    logic reply_valid_r;
    logic [REG_WIDTH-1:0] reply_r;
    logic [BUF_COUNT_WIDTH-1:0] half_level;

    // registered status outputs
    logic fault_light_r;
    logic meas_summary_r;
    logic ques_summary_r;
    logic oper_summary_r;

    // decode of which register a query selects
    function automatic logic sel_hit(input sev_query_type q,
                                     input logic [1:0] which);
        sel_hit = q.valid && (q.sel == which);
    endfunction

    // any latched bit that its enable lets through;
    // shared by the three summary levels
    function automatic logic masked_any(input logic [REG_WIDTH-1:0] val,
                                        input logic [REG_WIDTH-1:0] en);
        masked_any = |(val & en);
    endfunction

    assign rd_meas = sel_hit(query_in, SEL_MEASUREMENT);
    assign rd_ques = sel_hit(query_in, SEL_QUESTIONABLE);
    assign rd_oper = sel_hit(query_in, SEL_OPERATION);

    assign half_level = buf_capacity_in >> 1;

    // measurement event sources
    always_comb
    begin
        meas_set = LATCH_RESET;
        // [RL3] overflow flag
        meas_set[BIT_READING_OVERFLOW] = reading_in.reading_done
            && reading_in.reading_overflow;
        // [RL4] lower limit one
        meas_set[BIT_LOWER_LIMIT_ONE] = reading_in.reading_done
            && reading_in.lower_limit_one_crossed;
        // [RL5] upper limit one
        meas_set[BIT_UPPER_LIMIT_ONE] = reading_in.reading_done
            && reading_in.upper_limit_one_crossed;
        // [RL6] lower limit two
        meas_set[BIT_LOWER_LIMIT_TWO] = reading_in.reading_done
            && reading_in.lower_limit_two_crossed;
        // [RL7] upper limit two
        meas_set[BIT_UPPER_LIMIT_TWO] = reading_in.reading_done
            && reading_in.upper_limit_two_crossed;
        // [RL8] reading ready flag
        meas_set[BIT_READING_READY] = reading_in.reading_done;
        // [RL9] buffer has data
        meas_set[BIT_BUFFER_HAS_DATA] = buf_count_in >= BUF_HAS_DATA_MIN;
        // [RL10] buffer half flag
        meas_set[BIT_BUFFER_HALF] = (buf_capacity_in != '0)
            && (buf_count_in >= half_level);
        // [RL11] buffer complete flag
        meas_set[BIT_BUFFER_COMPLETE] = (buf_capacity_in != '0)
            && (buf_count_in >= buf_capacity_in);
    end

    // [RL14] cal invalid held until good calibration
    always_comb
    begin
        cal_invalid_nxt = cal_invalid_r;
        if (state_in.cal_done_ok)
        begin
            cal_invalid_nxt = 1'b0;
        end
        if (state_in.cal_constant_invalid)
        begin
            cal_invalid_nxt = 1'b1;
        end
    end

    // calibration condition register
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            cal_invalid_r <= 1'b0;
        end
        else
        begin
            cal_invalid_r <= cal_invalid_nxt;
        end
    end

    // [RL13] default constant substituted while invalid
    assign use_default_cal_out = cal_invalid_r;

    // questionable event sources
    always_comb
    begin
        ques_set = LATCH_RESET;
        // [RL12] reference junction invalid
        ques_set[BIT_TEMP_SUMMARY] = state_in.temp_ref_invalid;
        // [RL13] calibration summary bit
        ques_set[BIT_CAL_SUMMARY] = cal_invalid_r;
        // [RL15] command warning bit
        ques_set[BIT_CMD_WARNING] = state_in.cmd_param_ignored;
    end

    // operation event sources
    always_comb
    begin
        oper_set = LATCH_RESET;
        // [RL17] measuring bit
        oper_set[BIT_MEASURING] = state_in.measuring;
        // [RL18] trigger device action
        oper_set[BIT_TRIGGERING] = state_in.device_action;
        // [RL19] idle bit
        oper_set[BIT_IDLE] = state_in.idle;
    end

    // [RL21] sticky latches, unused bits masked
    sev_latch16 u_meas
    (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .set_in(meas_set),
        .used_mask_in(MEAS_USED_MASK),
        .read_in(rd_meas),
        .value_out(meas_val)
    );

    sev_latch16 u_ques
    (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .set_in(ques_set),
        .used_mask_in(QUES_USED_MASK),
        .read_in(rd_ques),
        .value_out(ques_val)
    );

    sev_latch16 u_oper
    (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .set_in(oper_set),
        .used_mask_in(OPER_USED_MASK),
        .read_in(rd_oper),
        .value_out(oper_val)
    );

    // [RL2] reply captures the weighted bit value
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            reply_r <= LATCH_RESET;
        end
        else if (rd_meas)
        begin
            reply_r <= meas_val;
        end
        else if (rd_ques)
        begin
            reply_r <= ques_val;
        end
        else if (rd_oper)
        begin
            reply_r <= oper_val;
        end
    end

    // [RL1] reply marked in the cycle the clear lands
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            reply_valid_r <= 1'b0;
        end
        else
        begin
            reply_valid_r <= rd_meas | rd_ques | rd_oper;
        end
    end

    assign reply_valid_out = reply_valid_r;
    assign reply_value_out = reply_r;

    // [RL16] fault light while any questionable bit set
    // registered so the lamp never sees decode glitches
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            fault_light_r <= 1'b0;
        end
        else
        begin
            fault_light_r <= |ques_val;
        end
    end

    // [RL20] measurement summary, masked bits held back
    // summaries lag the latch by one clock, like the lamp
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            meas_summary_r <= 1'b0;
        end
        else
        begin
            meas_summary_r <= masked_any(meas_val, meas_enable_in);
        end
    end

    // [RL20] questionable summary through its mask
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            ques_summary_r <= 1'b0;
        end
        else
        begin
            ques_summary_r <= masked_any(ques_val, ques_enable_in);
        end
    end

    // [RL20] operation summary through its mask
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            oper_summary_r <= 1'b0;
        end
        else
        begin
            oper_summary_r <= masked_any(oper_val, oper_enable_in);
        end
    end

    // status outputs straight from their flops
    assign fault_light_out = fault_light_r;
    assign meas_summary_out = meas_summary_r;
    assign ques_summary_out = ques_summary_r;
    assign oper_summary_out = oper_summary_r;

endmodule // sev_status_bank

/* bench/sev_chk.sv */
// sev_chk: port checks for the status event bank
// assumes a bind onto sev_status_bank, one clock, sync reset
`timescale 1ns/10ps
module sev_chk
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire sev_pkg::sev_reading_type reading_in,
    input wire sev_pkg::sev_state_type state_in,
    input wire sev_pkg::sev_query_type query_in,
    input wire logic reply_valid_out,
    input wire logic [15:0] reply_value_out,
    input wire logic use_default_cal_out,
    input wire logic fault_light_out,
    input wire logic ques_summary_out
);
    import sev_pkg::*;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    // a query taken on one register
    sequence s_rd(logic [1:0] s);
        query_in.valid && query_in.sel == s;
    endsequence
    a_reply_taken: assert property (query_in.valid && query_in.sel != 2'h3
        |=> reply_valid_out) else $error("reply missing");
    a_no_reply: assert property (!(query_in.valid && query_in.sel != 2'h3)
        |=> !reply_valid_out) else $error("reply without query");
    a_read_clears: assert property (s_rd(2'h2) ##0 state_in[2:0] == 3'h0
        ##1 s_rd(2'h2) |=> reply_value_out == 16'h0000)
        else $error("read did not clear");
    a_unused_zero: assert property (s_rd(2'h0)
        |=> (reply_value_out & ~MEAS_USED_MASK) == 16'h0000)
        else $error("unused bit set");
    a_idle_seen: assert property (state_in.idle ##1 s_rd(2'h2)
        |=> reply_value_out[BIT_IDLE]) else $error("idle bit lost");
    a_ready_seen: assert property (reading_in.reading_done
        ##1 !query_in.valid ##1 s_rd(2'h0)
        |=> reply_value_out[BIT_READING_READY]) else $error("ready bit lost");
    a_cal_default: assert property (state_in.cal_constant_invalid
        |-> ##[1:2] use_default_cal_out) else $error("no default cal");
    a_fault_light: assert property (ques_summary_out
        |-> fault_light_out) else $error("fault light off");
endmodule // sev_chk

/* bench/sev_host.sv */
// sev_host: host model issuing status queries
// assumes calls from one process; drives at the falling edge
`timescale 1ns/10ps
module sev_host
(
    input wire logic mclk_in,
    input wire logic reply_valid_in,
    input wire logic [15:0] reply_value_in,
    output sev_pkg::sev_query_type query_out
);
    import sev_pkg::*;
    initial query_out = '0;
    // n back-to-back strobes, then take the last reply
    task automatic query(input logic [1:0] sel, input int n,
        output logic [15:0] value, output logic ok);
        ok = 1'b0;
        value = 16'h0000;
        @(negedge mclk_in);
        query_out = {1'b1, sel};
        repeat (n) @(negedge mclk_in);
        query_out.valid = 1'b0;
        for (int i = 0; i < 4 && !ok; i++)
        begin
            ok = (reply_valid_in === 1'b1);
            value = reply_value_in;
            if (!ok)
                @(negedge mclk_in);
        end
    endtask
endmodule // sev_host

/* bench/sev_status_bank_tb.sv */
// sev_status_bank_tb: self-checking bench for the event bank
// assumes the host model makes every query; events change at falling edge
`timescale 1ns/10ps
module sev_status_bank_tb;
    import sev_pkg::*;
    logic mclk_in, rst_in, ok, reply_valid_out, use_default_cal_out;
    logic fault_light_out, meas_summary_out, ques_summary_out;
    logic oper_summary_out;
    sev_reading_type reading_in;
    sev_state_type state_in;
    sev_query_type query_in;
    logic [10:0] buf_count_in, buf_capacity_in;
    logic [15:0] meas_enable_in, ques_enable_in, oper_enable_in;
    logic [15:0] reply_value_out, v;
    int n_fail = 0;
    int n_tests = 0;
    sev_status_bank sev_status_bank_i
    (
        .mclk_in, .rst_in, .reading_in, .state_in, .buf_count_in,
        .buf_capacity_in, .query_in, .meas_enable_in, .ques_enable_in,
        .oper_enable_in, .reply_valid_out, .reply_value_out,
        .use_default_cal_out, .fault_light_out, .meas_summary_out,
        .ques_summary_out, .oper_summary_out
    );
    sev_host sev_host_i
    (
        .mclk_in, .reply_valid_in(reply_valid_out),
        .reply_value_in(reply_value_out), .query_out(query_in)
    );
    // 50 MHz clock
    initial
    begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [1:0] sel, input int n,
        input logic [15:0] exp);
        sev_host_i.query(sel, n, v, ok);
        chk({15'h0000, ok}, 16'h0001);
        chk(v, exp);
    endtask
    task automatic end_sim;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // hang guard
    initial
    begin
        #200000;
        n_fail++;
        end_sim();
    end
    // main sequence
    initial
    begin
        rst_in = 1'b1;
        reading_in = '0;
        state_in = '0;
        buf_count_in = 11'h000;
        buf_capacity_in = 11'h008;
        meas_enable_in = 16'h0000;
        ques_enable_in = 16'hffff;
        oper_enable_in = 16'h0000;
        repeat (12) @(negedge mclk_in);
        rst_in = 1'b0;
        for (int s = 0; s < 3; s++)
            rd(s[1:0], 1, 16'h0000);
        reading_in = '1;
        @(negedge mclk_in);
        reading_in = 6'h24; // done with upper limit one only
        @(negedge mclk_in);
        reading_in = '0;
        rd(SEL_MEASUREMENT, 1, 16'h003f);
        reading_in = 6'h24;
        @(negedge mclk_in);
        reading_in = '0;
        rd(SEL_MEASUREMENT, 1, 16'h0024);
        rd(SEL_MEASUREMENT, 1, 16'h0000);
        buf_count_in = 11'h002;
        rd(SEL_MEASUREMENT, 2, 16'h0080);
        buf_count_in = 11'h004;
        rd(SEL_MEASUREMENT, 2, 16'h0180);
        buf_count_in = 11'h008;
        rd(SEL_MEASUREMENT, 2, 16'h0380);
        buf_count_in = 11'h001;
        rd(SEL_MEASUREMENT, 2, 16'h0000);
        state_in = 7'h07; // measuring, device action, idle
        rd(SEL_OPERATION, 2, 16'h0430);
        state_in = '0;
        rd(SEL_OPERATION, 2, 16'h0000);
        state_in = 7'h48; // temperature and command warnings
        @(negedge mclk_in);
        state_in = '0;
        @(negedge mclk_in);
        chk({15'h0000, fault_light_out}, 16'h0001);
        chk({15'h0000, ques_summary_out}, 16'h0001);
        rd(SEL_QUESTIONABLE, 1, 16'h4010);
        @(negedge mclk_in);
        chk({15'h0000, fault_light_out}, 16'h0000);
        chk({15'h0000, ques_summary_out}, 16'h0000);
        state_in.cal_constant_invalid = 1'b1;
        @(negedge mclk_in);
        state_in = '0;
        repeat (3) @(negedge mclk_in);
        chk({15'h0000, use_default_cal_out}, 16'h0001);
        rd(SEL_QUESTIONABLE, 2, 16'h0100);
        state_in.cal_done_ok = 1'b1;
        @(negedge mclk_in);
        state_in = '0;
        rd(SEL_QUESTIONABLE, 3, 16'h0000);
        chk({15'h0000, use_default_cal_out}, 16'h0000);
        meas_enable_in = 16'h0200; // only buffer complete passes
        reading_in = 6'h24;
        @(negedge mclk_in);
        reading_in = '0;
        @(negedge mclk_in);
        chk({15'h0000, meas_summary_out}, 16'h0000);
        meas_enable_in = 16'h0020;
        @(negedge mclk_in);
        chk({15'h0000, meas_summary_out}, 16'h0001);
        rd(SEL_MEASUREMENT, 1, 16'h0024);
        @(negedge mclk_in);
        chk({15'h0000, meas_summary_out}, 16'h0000);
        oper_enable_in = 16'h0400; // only idle passes
        state_in = 7'h04;
        @(negedge mclk_in);
        state_in = '0;
        @(negedge mclk_in);
        chk({15'h0000, oper_summary_out}, 16'h0000);
        state_in = 7'h01;
        @(negedge mclk_in);
        state_in = '0;
        @(negedge mclk_in);
        chk({15'h0000, oper_summary_out}, 16'h0001);
        rd(SEL_OPERATION, 1, 16'h0410);
        sev_host_i.query(2'h3, 1, v, ok);
        chk({15'h0000, ok}, 16'h0000);
        end_sim();
    end
endmodule // sev_status_bank_tb
bind sev_status_bank sev_chk sev_chk_i
(
    .mclk_in, .rst_in, .reading_in, .state_in, .query_in, .reply_valid_out,
    .reply_value_out, .use_default_cal_out, .fault_light_out,
    .ques_summary_out
);
